// File: hw/ltdt_top.sv
// latency descriptor table with latency setting and dummy cycle counter
//
// Behaviour
// [R1] 28 dummy cycles flagged supported, pattern 01111b.
// [R2] 26 cycles supported, pattern 01101b in bits 18:14.
// [R3] 24 cycles supported, pattern 01011b in bits 12:8.
// [R4] 22 cycles supported, pattern 01001b in bits 6:2; bits 1:0 zero.
// [R5] next word: 20 cycles flagged in bit 31, pattern 01000b at 30:26.
// [R6] 18 cycles supported, pattern 00111b.
// [R7] 16 cycles supported, pattern 00110b.
// [R8] 14 cycles supported, pattern 00101b.
// [R9] 12 cycles supported, pattern 00100b.
// [R10] third word: 10 cycles flagged in bit 31, pattern 00011b.
// [R11] 8 cycles supported, pattern 00010b.
// [R12] 6 cycles supported, pattern 00001b.
// [R13] 4 cycles unsupported, flag and pattern zero.
// [R14] 2 cycles unsupported, flag and pattern zero.
// [R15] bytes 196h and 197h read FBh and 02h.
// [R16] bytes 19Ch to 19Fh read 00h, 40h, 28h, 8Eh.
// [R17] 30 cycles unsupported, flag and pattern zero.
// [R18] latency setting is a writable, readable four-bit field at bit 0.
// [R19] selected dummy cycles inserted between address phase and first data.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module ltdt_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // read sequencer
    input wire logic sck_tick_i,
    input wire logic addr_done_i,
    output logic dummy_busy_o,
    output logic data_start_o,
    output logic [3:0] lat_sel_o
);

    ltdt_pkg::ltdt_req_s req;
    ltdt_pkg::ltdt_word_s word_a;
    ltdt_pkg::ltdt_word_s word_b;
    ltdt_pkg::ltdt_word_s word_c;

    logic [31:0] rdata_r, rdata_nxt;
    logic [3:0] lat_r, lat_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic start_r, start_nxt;
    logic [4:0] sel_cycles;

    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    // fixed descriptor words; word a upper half answers bytes 196h/197h
    always_comb begin
        word_a.s0 = '{sup: 1'b0, pat: ltdt_pkg::LTDT_PAT_NONE}; // [R17]
        word_a.s1 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_28}; // [R1] [R15]
        word_a.s2 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_26}; // [R2] [R15]
        word_a.s3 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_24}; // [R3]
        word_a.s4 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_22}; // [R4]
        word_a.rsvd = 2'h0; // [R4]
        word_b.s0 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_20}; // [R5]
        word_b.s1 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_18}; // [R6]
        word_b.s2 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_16}; // [R7]
        word_b.s3 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_14}; // [R8]
        word_b.s4 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_12}; // [R9]
        word_b.rsvd = 2'h0;
        word_c.s0 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_10}; // [R10] [R16]
        word_c.s1 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_8}; // [R11] [R16]
        word_c.s2 = '{sup: 1'b1, pat: ltdt_pkg::LTDT_PAT_6}; // [R12] [R16]
        word_c.s3 = '{sup: 1'b0, pat: ltdt_pkg::LTDT_PAT_NONE}; // [R13] [R16]
        word_c.s4 = '{sup: 1'b0, pat: ltdt_pkg::LTDT_PAT_NONE}; // [R14] [R16]
        word_c.rsvd = 2'h0; // [R16]
    end

    // register port: write setting, registered read data for one cycle
    always_comb begin
        lat_nxt = lat_r;
        rdata_nxt = 32'h0000_0000;
        if (req.wr && req.addr == ltdt_pkg::LTDT_OFF_LAT_CFG) begin
            lat_nxt = req.wdata[ltdt_pkg::LTDT_LAT_LSB +: ltdt_pkg::LTDT_LAT_W]; // [R18]
        end
        if (req.rd) begin
            unique case (req.addr)
                ltdt_pkg::LTDT_OFF_WORD_A: rdata_nxt = word_a; // [R15]
                ltdt_pkg::LTDT_OFF_WORD_B: rdata_nxt = word_b;
                ltdt_pkg::LTDT_OFF_WORD_C: rdata_nxt = word_c; // [R16]
                ltdt_pkg::LTDT_OFF_LAT_CFG: begin
                    rdata_nxt[ltdt_pkg::LTDT_LAT_LSB +: ltdt_pkg::LTDT_LAT_W] = lat_r; // [R18]
                end
                ltdt_pkg::LTDT_OFF_LAT_STAT: begin
                    rdata_nxt[ltdt_pkg::LTDT_CNT_W-1:0] = cnt_r;
                    rdata_nxt[ltdt_pkg::LTDT_STAT_BUSY] = busy_r;
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lat_r <= ltdt_pkg::LTDT_LAT_RESET;
            rdata_r <= 32'h0000_0000;
        end else begin
            lat_r <= lat_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // setting sampled at the address phase end; a write mid-gap waits for the next read
    assign sel_cycles = ltdt_pkg::LTDT_CYC_LUT[lat_r*ltdt_pkg::LTDT_CNT_W +: ltdt_pkg::LTDT_CNT_W];

    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        start_nxt = 1'b0;
        if (addr_done_i) begin
            cnt_nxt = sel_cycles; // [R19]
            busy_nxt = 1'b1;
        end else if (busy_r && sck_tick_i) begin
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
                busy_nxt = 1'b0;
                start_nxt = 1'b1; // [R19]
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 5'h00;
            busy_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            start_r <= start_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign dummy_busy_o = busy_r;
    assign data_start_o = start_r;
    assign lat_sel_o = lat_r;

endmodule

// File: inc/ltdt_pkg.sv
// package for the latency descriptor table block
package ltdt_pkg;

    // one latency slot: support flag and selecting pattern
    typedef struct packed {
        logic sup;
        logic [4:0] pat;
    } ltdt_slot_s;

    // descriptor word: five slots from the top, two reserved bits
    typedef struct packed {
        ltdt_slot_s s0;
        ltdt_slot_s s1;
        ltdt_slot_s s2;
        ltdt_slot_s s3;
        ltdt_slot_s s4;
        logic [1:0] rsvd;
    } ltdt_word_s;

    // register bus request as seen inside the block
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ltdt_req_s;

    // register byte addresses
    localparam logic [11:0] LTDT_OFF_WORD_A = 12'h194;
    localparam logic [11:0] LTDT_OFF_WORD_B = 12'h198;
    localparam logic [11:0] LTDT_OFF_WORD_C = 12'h19C;
    localparam logic [11:0] LTDT_OFF_LAT_CFG = 12'h200;
    localparam logic [11:0] LTDT_OFF_LAT_STAT = 12'h204;

    // latency setting field and dummy count width
    localparam int LTDT_LAT_W = 4;
    localparam int LTDT_LAT_LSB = 0;
    localparam logic [3:0] LTDT_LAT_RESET = 4'h8;
    localparam int LTDT_CNT_W = 5;

    // selecting patterns
    localparam logic [4:0] LTDT_PAT_NONE = 5'h00;
    localparam logic [4:0] LTDT_PAT_28 = 5'h0F;
    localparam logic [4:0] LTDT_PAT_26 = 5'h0D;
    localparam logic [4:0] LTDT_PAT_24 = 5'h0B;
    localparam logic [4:0] LTDT_PAT_22 = 5'h09;
    localparam logic [4:0] LTDT_PAT_20 = 5'h08;
    localparam logic [4:0] LTDT_PAT_18 = 5'h07;
    localparam logic [4:0] LTDT_PAT_16 = 5'h06;
    localparam logic [4:0] LTDT_PAT_14 = 5'h05;
    localparam logic [4:0] LTDT_PAT_12 = 5'h04;
    localparam logic [4:0] LTDT_PAT_10 = 5'h03;
    localparam logic [4:0] LTDT_PAT_8 = 5'h02;
    localparam logic [4:0] LTDT_PAT_6 = 5'h01;

    // dummy cycle count per setting value, index 0 in the low bits
    localparam logic [79:0] LTDT_CYC_LUT = {
        5'h1C, 5'h1A, 5'h1A, 5'h18, 5'h18, 5'h16, 5'h16, 5'h14,
        5'h12, 5'h10, 5'h0E, 5'h0C, 5'h0A, 5'h08, 5'h06, 5'h04
    };

    // status fields
    localparam int LTDT_STAT_BUSY = 8;

endpackage

// File: tb/ltdt_monitor.sv
// assertions on the latency table ports
`timescale 1ns/1ps
module ltdt_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // read sequencer
    input wire logic sck_tick_i,
    input wire logic addr_done_i,
    input wire logic dummy_busy_o,
    input wire logic data_start_o,
    input wire logic [3:0] lat_sel_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic wr_cfg = wr_i && addr_i == 12'h200;
    a_word_a: assert property (rd_i && addr_i == 12'h194 |=> rdata_o == 32'h02FB6BA4)
        else $error("word a wrong");
    a_word_b: assert property (rd_i && addr_i == 12'h198 |=> rdata_o == 32'hA279A590)
        else $error("word b wrong");
    a_word_c: assert property (rd_i && addr_i == 12'h19C |=> rdata_o == 32'h8E284000)
        else $error("word c wrong");
    a_rd_idle: assert property (!rd_i |=> rdata_o == 32'h0) else $error("stale read data");
    a_cfg_wr: assert property (wr_cfg |=> lat_sel_o == $past(wdata_i[3:0]))
        else $error("setting not written");
    a_lat_hold: assert property (!wr_cfg |=> $stable(lat_sel_o))
        else $error("setting moved");
    a_busy_load: assert property (addr_done_i |=> dummy_busy_o && !data_start_o)
        else $error("no dummy phase");
    a_start_end: assert property ($fell(dummy_busy_o) |-> data_start_o)
        else $error("busy fell without start");
    a_six_cycles: assert property (addr_done_i && lat_sel_o == 4'h1
        ##1 (sck_tick_i && !addr_done_i)[*6] |=> data_start_o) else $error("six count wrong");
    c_start: cover property (data_start_o);
    c_read_c: cover property (rd_i && addr_i == 12'h19C);
    c_cfg: cover property (wr_cfg);
endmodule
bind ltdt_top ltdt_monitor i_ltdt_monitor (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .sck_tick_i, .addr_done_i, .dummy_busy_o, .data_start_o, .lat_sel_o);

// File: tb/ltdt_host.sv
// host side model: ends address phase, then clocks dummy cycles
`timescale 1ns/1ps
module ltdt_host (
    // clock
    input wire logic clk_i,
    // test control
    input wire logic go_i,
    input wire logic slow_i,
    input wire logic start_i,
    // sequencer drive
    output logic sck_tick_o = 1'b0,
    output logic addr_done_o = 1'b0
);
    logic frame_r = 1'b0;
    // ticks only inside a frame; slow mode halves the serial rate
    always_ff @(posedge clk_i) begin
        addr_done_o <= go_i;
        frame_r <= go_i | (frame_r & ~start_i);
        sck_tick_o <= frame_r & ~start_i & (~slow_i | ~sck_tick_o);
    end
endmodule

// File: tb/tb.sv
// testbench for the latency descriptor table
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rdata_o;
    logic sck_tick_i, addr_done_i, dummy_busy_o, data_start_o;
    logic [3:0] lat_sel_o;
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    logic [3:0] lv [4] = '{4'h1, 4'h9, 4'hF, 4'h0};
    int ev [4] = '{7, 23, 29, 5};
    ltdt_top i_ltdt_top (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .sck_tick_i, .addr_done_i, .dummy_busy_o, .data_start_o, .lat_sel_o);
    ltdt_host i_ltdt_host (.clk_i, .go_i(go), .slow_i(slow), .start_i(data_start_o),
        .sck_tick_o(sck_tick_i), .addr_done_o(addr_done_i));
    initial forever #50 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    // cycles from end of address phase to first data, counted after the edge
    task automatic dum(input logic [3:0] lat, input logic s, input int exp);
        wr(12'h200, {28'h0, lat});
        slow <= s;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (data_start_o !== 1'b1 && n < 100);
        chk(n, exp);
        chk({28'h0, lat_sel_o}, {28'h0, lat});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        chk({28'h0, lat_sel_o}, 32'h8);
        rd(12'h194, 32'h02FB6BA4);
        wr(12'h198, 32'h0);
        rd(12'h198, 32'hA279A590);
        rd(12'h19C, 32'h8E284000);
        rd(12'h1A0, 32'h0);
        rd(12'h204, 32'h0);
        rd(12'h200, 32'h8);
        $display("test table done");
        for (int i = 0; i < 4; i++) dum(lv[i], 1'b0, ev[i]);
        dum(4'h1, 1'b1, 12);
        rd(12'h200, 32'h1);
        $display("test latency done");
        stop_test;
    end
    // run needs about 115 cycles
    initial begin
        #1000000 error_cnt++;
        $display("unexpected at %0t: run hung", $time);
        stop_test;
    end
endmodule
